/* logic/fpled_pkg.sv */
package fpled_pkg;
  // clock and scan timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int ROW_TIME_NS = 1000000;
  localparam int ROW_CYCLES = (ROW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIV_W = 20;

  // matrix geometry
  localparam int BYTE_W = 8;
  localparam int LED_ROWS = 8;
  localparam int LED_COLS = 16;
  localparam int BAR_COUNT = 10;
  localparam int BAR_SEGS = 10;
  localparam int DISCRETE_LEDS = 1;
  localparam int LED_POPULATED = BAR_COUNT * BAR_SEGS + DISCRETE_LEDS;
  localparam int KEY_COLS = 3;
  localparam int KEY_ROWS = 4;
  localparam int KEY_COUNT = 11;
  localparam int STATUS_LEDS = 5;

  // latch select codes on the write port
  localparam logic [4:0] SEL_METER_LAST = 5'h0F;
  localparam logic [4:0] SEL_STATUS = 5'h10;

  // reset values
  localparam logic [2:0] ROW_RESET = 3'h0;
  localparam logic [1:0] KCOL_RESET = 2'h0;
  localparam logic [7:0] LATCH_RESET = 8'h00;

  // one byte-wide latch write
  typedef struct packed {
    logic [4:0] sel;
    logic [7:0] data;
  } fpled_wr_type;

  typedef enum logic [0:0] {
    KS_IDLE = 1'b0,
    KS_SCAN = 1'b1
  } fpled_ks_type;
endpackage

/* logic/fpled_top.sv */
`timescale 1ns/1ps
module fpled_top #(
  parameter int ROW_CYC = fpled_pkg::ROW_CYCLES
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic wr_stb_i,
  input wire fpled_pkg::fpled_wr_type wr_i,
  input wire logic [3:0] key_row_i,
  output logic [7:0] led_row_o,
  output logic [15:0] led_col_o,
  output logic [4:0] status_led_o,
  output logic [2:0] key_col_o,
  output logic [10:0] key_state_o
);

  // one-hot decode, shared by the LED rows and the key columns
  function automatic logic [7:0] onehot8(input logic [2:0] idx);
    onehot8 = 8'h01 << idx;
  endfunction

  logic [fpled_pkg::DIV_W-1:0] div_q, div_d;
  logic tick;
  logic [2:0] row_q, row_d;
  logic [7:0] led_row_d;
  logic [15:0] led_col_d;
  logic [7:0] meter_q [16];
  logic [7:0] meter_d [16];
  logic [4:0] status_d;
  logic [15:0] pop_mask [8];
  fpled_pkg::fpled_ks_type ks_q, ks_d;
  logic [1:0] kcol_q, kcol_d;
  logic [2:0] key_col_d;
  logic [7:0] kcol_hot;
  logic [11:0] key_raw_q, key_raw_d;

  // unpopulated positions are masked so stray bits never light a pad
  for (genvar r = 0; r < fpled_pkg::LED_ROWS; r++) begin : g_row
    for (genvar c = 0; c < fpled_pkg::LED_COLS; c++) begin : g_col
      assign pop_mask[r][c] =
        ((r * fpled_pkg::LED_COLS + c) < fpled_pkg::LED_POPULATED);
    end
  end

  // row-time divider; one tick per row slot
  assign tick = (div_q == fpled_pkg::DIV_W'(ROW_CYC - 1));

  // scan timing next state
  always_comb begin
    div_d = tick ? '0 : div_q + 1'b1;
    row_d = tick ? row_q + 3'h1 : row_q;
    led_row_d = onehot8(row_d);
  end

  // meter and status latches, byte per write
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      meter_d[i] = meter_q[i];
    end
    status_d = status_led_o;
    if (wr_stb_i && wr_i.sel <= fpled_pkg::SEL_METER_LAST) begin
      meter_d[wr_i.sel[3:0]] = wr_i.data;
    end
    if (wr_stb_i && wr_i.sel == fpled_pkg::SEL_STATUS) begin
      status_d = wr_i.data[4:0];
    end
  end

  // column drive follows the row about to be selected
  always_comb begin
    led_col_d = {meter_q[{row_d, 1'b1}], meter_q[{row_d, 1'b0}]}
                & pop_mask[row_d];
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      div_q <= '0;
      row_q <= fpled_pkg::ROW_RESET;
      led_row_o <= 8'h01;
      led_col_o <= 16'h0000;
      status_led_o <= 5'h00;
      for (int i = 0; i < 16; i++) begin
        meter_q[i] <= fpled_pkg::LATCH_RESET;
      end
    end else begin
      div_q <= div_d;
      row_q <= row_d;
      led_row_o <= led_row_d;
      led_col_o <= led_col_d;
      status_led_o <= status_d;
      for (int i = 0; i < 16; i++) begin
        meter_q[i] <= meter_d[i];
      end
    end
  end

  // key scan: a column settles for a whole row slot before it is sampled
  always_comb begin
    ks_d = ks_q;
    kcol_d = kcol_q;
    key_raw_d = key_raw_q;
    case (ks_q)
      fpled_pkg::KS_IDLE: begin
        if (tick) begin
          ks_d = fpled_pkg::KS_SCAN;
        end
      end
      fpled_pkg::KS_SCAN: begin
        if (tick) begin
          key_raw_d[{kcol_q, 2'b00} +: 4] = key_row_i;
          kcol_d = (kcol_q == 2'(fpled_pkg::KEY_COLS - 1)) ? 2'h0
                   : kcol_q + 2'h1;
        end
      end
      default: begin
        ks_d = fpled_pkg::KS_IDLE;
      end
    endcase
    // only the low three of the eight decoded lines reach the keys
    kcol_hot = onehot8({1'b0, kcol_d});
    key_col_d = kcol_hot[2:0];
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ks_q <= fpled_pkg::KS_IDLE;
      kcol_q <= fpled_pkg::KCOL_RESET;
      key_raw_q <= 12'h000;
      key_col_o <= 3'h1;
      key_state_o <= 11'h000;
    end else begin
      ks_q <= ks_d;
      kcol_q <= kcol_d;
      key_raw_q <= key_raw_d;
      key_col_o <= key_col_d;
      key_state_o <= key_raw_d[10:0]; // twelfth crossing is unpopulated
    end
  end

  // helper: cycles the current row has been shown
  logic [fpled_pkg::DIV_W-1:0] held_q;
  logic [7:0] prev_row_q;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      held_q <= '0;
      prev_row_q <= 8'h01;
    end else begin
      held_q <= (led_row_o != prev_row_q) ? fpled_pkg::DIV_W'(1)
                : held_q + 1'b1;
      prev_row_q <= led_row_o;
    end
  end

  row_onehot_a: assert property (@(posedge clk_i)
    disable iff (srst_i) $onehot(led_row_o))
    else $error("more or fewer than one led row enabled");

  row_order_a: assert property (@(posedge clk_i)
    disable iff (srst_i)
    tick |=> led_row_o == {$past(led_row_o[6:0]), $past(led_row_o[7])})
    else $error("led rows not visited in ascending order");

  row_duty_a: assert property (@(posedge clk_i)
    disable iff (srst_i)
    (led_row_o != prev_row_q) |-> held_q == fpled_pkg::DIV_W'(ROW_CYC))
    else $error("led row slot length wrong");

  col_mask_a: assert property (@(posedge clk_i)
    disable iff (srst_i)
    (led_col_o & ~pop_mask[row_q]) == 16'h0000)
    else $error("unpopulated led column driven");

  col_pattern_a: assert property (@(posedge clk_i)
    disable iff (srst_i)
    !$past(wr_stb_i) |-> led_col_o ==
      ({meter_q[{row_q, 1'b1}], meter_q[{row_q, 1'b0}]} & pop_mask[row_q]))
    else $error("column drive does not match selected row");

  byte_write_a: assert property (@(posedge clk_i)
    disable iff (srst_i)
    wr_stb_i && wr_i.sel <= fpled_pkg::SEL_METER_LAST |=>
      meter_q[$past(wr_i.sel[3:0])] == $past(wr_i.data))
    else $error("meter byte not latched");

  status_write_a: assert property (@(posedge clk_i)
    disable iff (srst_i)
    wr_stb_i && wr_i.sel == fpled_pkg::SEL_STATUS |=>
      status_led_o == $past(wr_i.data[4:0]))
    else $error("status leds not latched");

  key_sample_a: assert property (@(posedge clk_i)
    disable iff (srst_i)
    tick && ks_q == fpled_pkg::KS_SCAN |=>
      key_raw_q[{$past(kcol_q), 2'b00} +: 4] == $past(key_row_i))
    else $error("key rows not captured for column");

  key_col_a: assert property (@(posedge clk_i)
    disable iff (srst_i)
    $onehot(key_col_o) && key_col_o == (3'h1 << kcol_q))
    else $error("key column drive not one-hot");

  row_wrap_c: cover property (@(posedge clk_i) disable iff (srst_i)
    led_row_o == 8'h80 ##1 led_row_o == 8'h01);
  key_press_c: cover property (@(posedge clk_i) disable iff (srst_i)
    key_state_o != 11'h000);
  status_wr_c: cover property (@(posedge clk_i) disable iff (srst_i)
    wr_stb_i && wr_i.sel == fpled_pkg::SEL_STATUS);
  meter_lit_c: cover property (@(posedge clk_i) disable iff (srst_i)
    led_col_o != 16'h0000);

endmodule

/* tb/fpled_keys.sv */
`timescale 1ns/1ps
// pushbutton matrix: row lines follow the keys under each driven column
module fpled_keys (
  input wire logic [2:0] key_col_i,
  input wire logic [10:0] pressed_i,
  output logic [3:0] key_row_o
);
  // several driven columns short their rows together, like real switches
  always_comb begin
    key_row_o = 4'h0;
    if (key_col_i[0]) key_row_o = key_row_o | pressed_i[3:0];
    if (key_col_i[1]) key_row_o = key_row_o | pressed_i[7:4];
    // no switch sits at column 2 row 3, so that line stays open
    if (key_col_i[2]) key_row_o = key_row_o | {1'b0, pressed_i[10:8]};
  end
endmodule

/* tb/front_panel_led_key_matrix_bench.sv */
`timescale 1ns/1ps
module front_panel_led_key_matrix_bench;
  logic clk_i;
  logic srst_i;
  logic wr_stb_i;
  fpled_pkg::fpled_wr_type wr_i;
  logic [3:0] key_row_i;
  logic [7:0] led_row_o;
  logic [15:0] led_col_o;
  logic [4:0] status_led_o;
  logic [2:0] key_col_o;
  logic [10:0] key_state_o;
  logic [10:0] pressed;
  logic [7:0] mb [16];
  int err_total;
  int comparisons;

  // short row slot keeps the scan within a few hundred cycles
  fpled_top #(.ROW_CYC(8)) u_fpled_top (.clk_i(clk_i), .srst_i(srst_i),
    .wr_stb_i(wr_stb_i), .wr_i(wr_i), .key_row_i(key_row_i),
    .led_row_o(led_row_o), .led_col_o(led_col_o),
    .status_led_o(status_led_o), .key_col_o(key_col_o),
    .key_state_o(key_state_o));
  fpled_keys u_fpled_keys (.key_col_i(key_col_o), .pressed_i(pressed),
    .key_row_o(key_row_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  task end_sim;
    if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // strobe stays up between calls so writes go back to back
  task wr(input logic [4:0] s, input logic [7:0] d);
    wr_stb_i = 1'b1;
    wr_i = '{sel: s, data: d};
    @(negedge clk_i);
  endtask

  // unpopulated positions past the last discrete LED never light
  function logic [15:0] exp_col(input int r);
    logic [15:0] v;
    v = {mb[2*r+1], mb[2*r]};
    for (int c = 0; c < 16; c++)
      if (r * 16 + c >= fpled_pkg::LED_POPULATED) v[c] = 1'b0;
    return v;
  endfunction

  task t_reset;
    chk(led_row_o === 8'h01, "reset row");
    chk(key_col_o === 3'h1, "reset key column");
    chk(status_led_o === 5'h00, "reset status");
    chk(key_state_o === 11'h000, "reset keys");
    chk(led_col_o === 16'h0000, "reset columns");
  endtask

  // after a mid-run release the scan starts over and old state is gone
  task t_restart;
    srst_i = 1'b0;
    repeat (7) begin
      @(negedge clk_i);
      chk(led_row_o === 8'h01, "restart row");
      chk(led_col_o === 16'h0000, "restart meters");
    end
    @(negedge clk_i);
    chk(led_row_o === 8'h02, "restart slot");
    // the first slot after release is never sampled
    chk(key_state_o === 11'h000, "idle key slot");
  endtask

  task t_status;
    wr(5'h10, 8'hFF);
    wr(5'h11, 8'h00);
    wr(5'h1F, 8'h00);
    // an edge passes so the next task never re-raises the strobe at once
    wr_stb_i = 1'b0;
    @(negedge clk_i);
    chk(status_led_o === 5'h1F, "status or bad select");
  endtask

  task t_meter;
    int n;
    int idx;
    logic [7:0] r;
    // default slot must give a full refresh of at least 100 Hz
    chk(fpled_pkg::ROW_CYCLES <= 125000, "refresh too slow");
    for (int i = 0; i < 16; i++) begin
      mb[i] = 8'h5A ^ 8'(i * 37);
      wr(5'(i), mb[i]);
    end
    wr_stb_i = 1'b0;
    repeat (2) @(negedge clk_i);
    n = 0;
    r = led_row_o;
    while (led_row_o === r && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    idx = 0;
    for (int k = 0; k < 8; k++) if (led_row_o[k] === 1'b1) idx = k;
    // every slot lasts exactly eight cycles, rows in rising order
    for (int s = 0; s < 16; s++) begin
      repeat (8) begin
        chk(led_row_o === (8'h01 << idx), "row order");
        chk(led_col_o === exp_col(idx), "columns");
        @(negedge clk_i);
      end
      idx = (idx + 1) % 8;
    end
  endtask

  task t_keys(input logic [10:0] p);
    pressed = p;
    repeat (34) @(negedge clk_i);
    chk(key_state_o === p, "key state");
  endtask

  initial begin
    srst_i = 1'b1;
    wr_stb_i = 1'b0;
    wr_i = '0;
    pressed = 11'h000;
    repeat (3) @(negedge clk_i);
    t_reset();
    srst_i = 1'b0;
    t_status();
    t_meter();
    t_keys(11'h5A5);
    t_keys(11'h2C3);
    // a second reset in mid-run clears everything again
    srst_i = 1'b1;
    @(negedge clk_i);
    t_reset();
    t_restart();
    end_sim();
  end

  // the whole sequence needs well under a thousand cycles
  initial begin
    #20000;
    err_total++;
    $display("BAD %0t watchdog expired", $time);
    end_sim();
  end
endmodule
